// ===== src/dao_adc_end.sv
`timescale 1ns/10ps
`include "dao_regs.svh"
module dao_adc_end (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic signed [8:0] in_a_lsb,
   input wire logic signed [8:0] in_b_lsb,
   output dao_pkg::dao_mode_type mode_q,
   output logic adc_on_q,
   output logic ref_on_q,
   output logic clk_dist_on_q,
   dao_link_if.dev link
);
   import dao_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [1:0] pin_s1_q; // first sync stage
   logic [1:0] pin_s2_q; // second sync stage
   logic sclk_q; // divided sampling clock
   logic rise_ev; // sampling clock goes high
   logic fall_ev; // sampling clock goes low
   dao_code_type pipe_a_q [`DAO_LAT_A]; // first channel pipe
   dao_code_type pipe_b_q [`DAO_LAT_A]; // second channel pipe
   dao_code_type b_hold_q; // second word awaiting fall
   dao_code_type bus_q; // output latch
   logic ind_q; // channel indicator
   logic bus_oe_b_q; // bus enable, low drives
   logic ind_oe_b_q; // indicator enable, low drives

   // ----------------------------------------
   // coding
   // ----------------------------------------
   // clamp a signed lsb value to the offset binary range
   function automatic dao_code_type to_code(input logic signed [8:0] v);
      dao_code_type c;
      c = `DAO_CODE_MID;
      if (v >= `DAO_LSB_HI) begin
         c = `DAO_CODE_MAX;
      end else if (v <= `DAO_LSB_LO) begin
         c = `DAO_CODE_MIN;
      end else begin
         // flipping the sign bit maps zero to midscale
         c = v[7:0] ^ `DAO_CODE_MID;
      end
      return c;
   endfunction

   // ----------------------------------------
   // mode pins
   // ----------------------------------------
   // pins come from the other party: two stages first
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end else if (clk_en) begin
         pin_s1_q <= {link.power_mode_sel_hi, link.power_mode_sel_lo};
         pin_s2_q <= pin_s1_q;
      end
   end

   // decode mode only from the synced pins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= mode_shutdown;
      end else if (clk_en) begin
         unique case (pin_s2_q)
            2'b00: begin
               mode_q <= mode_shutdown;
            end
            2'b10: begin
               mode_q <= mode_standby; // hi pin set, lo pin clear
            end
            2'b01: begin
               mode_q <= mode_idle; // lo pin set, hi pin clear
            end
            2'b11: begin
               mode_q <= mode_normal;
            end
         endcase
      end
   end

   // ----------------------------------------
   // power sections
   // ----------------------------------------
   // section enables follow mode one cycle later
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         adc_on_q <= 1'b0;
         ref_on_q <= 1'b0;
         clk_dist_on_q <= 1'b0;
      end else if (clk_en) begin
         // shutdown: everything off
         ref_on_q <= (mode_q != mode_shutdown);
         clk_dist_on_q <= (mode_q != mode_shutdown);
         // converters only in idle and normal
         adc_on_q <= (mode_q == mode_idle) || (mode_q == mode_normal);
      end
   end

   // ----------------------------------------
   // output enables
   // ----------------------------------------
   // drivers released in every mode but normal
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_oe_b_q <= 1'b1;
         ind_oe_b_q <= 1'b1;
      end else if (clk_en) begin
         bus_oe_b_q <= (mode_q != mode_normal);
         ind_oe_b_q <= (mode_q != mode_normal);
      end
   end

   // ----------------------------------------
   // sampling clock
   // ----------------------------------------
   // half a sample period is one system cycle
   assign rise_ev = clk_dist_on_q && !sclk_q;
   assign fall_ev = sclk_q;

   // divider stops low while distribution is off
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q <= 1'b0;
      end else if (clk_en) begin
         sclk_q <= rise_ev;
      end
   end

   // ----------------------------------------
   // conversion pipeline
   // ----------------------------------------
   // both channels captured on the same rising edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `DAO_LAT_A; i++) begin
            pipe_a_q[i] <= `DAO_CODE_MID;
            pipe_b_q[i] <= `DAO_CODE_MID;
         end
      end else if (clk_en && rise_ev && adc_on_q) begin
         pipe_a_q[0] <= to_code(in_a_lsb);
         pipe_b_q[0] <= to_code(in_b_lsb);
         // a frozen pipe in low power keeps its words
         for (int i = 1; i < `DAO_LAT_A; i++) begin
            pipe_a_q[i] <= pipe_a_q[i-1];
            pipe_b_q[i] <= pipe_b_q[i-1];
         end
      end
   end

   // ----------------------------------------
   // output latch and indicator
   // ----------------------------------------
   // first word on rise, second half a period later
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_q <= `DAO_CODE_MID;
         b_hold_q <= `DAO_CODE_MID;
         ind_q <= 1'b0;
      end else if (clk_en && adc_on_q) begin
         if (rise_ev) begin
            // last stage is five sampling edges old
            bus_q <= pipe_a_q[`DAO_LAT_A-1];
            b_hold_q <= pipe_b_q[`DAO_LAT_A-1];
            ind_q <= 1'b1;
         end else if (fall_ev) begin
            bus_q <= b_hold_q;
            ind_q <= 1'b0;
         end
      end
      // with converters off the latch holds its word
   end

   // ----------------------------------------
   // pins out
   // ----------------------------------------
   // the latch feeds the bus directly, so re-enable shows the last word
   assign link.sample_out_bus = bus_q;
   assign link.bus_oe_b = bus_oe_b_q;
   assign link.chan_ind = ind_q;
   assign link.ind_oe_b = ind_oe_b_q;
   assign link.sample_clk = sclk_q;

endmodule

// ===== src/dao_ctrl_end.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dao_regs.svh"
// ----------------------------------------
// fifo
// ----------------------------------------
module dao_fifo #(
   parameter int WIDTH = `DAO_FIFO_WIDTH,
   parameter int DEPTH = `DAO_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage
   logic [AW:0] wr_q; // write pointer, wrap bit on top
   logic [AW:0] rd_q; // read pointer
   logic push; // accepted write
   logic pop; // accepted read

   assign level = wr_q - rd_q;
   assign in_ready = (level != DEPTH[AW:0] + (AW+1)'(0)) && (wr_q[AW] == rd_q[AW] || wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage has no reset: pointers guard it
   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (clk_en) begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// controller end
// ----------------------------------------
module dao_ctrl_end (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   dao_link_if.host link
);
   import dao_pkg::*;

   logic [2:0] ctrl_q; // mode pins and reference kind
   logic [15:0] unbuf_wait_q; // wake wait, unbuffered reference
   logic [15:0] wait_cnt_q; // wake countdown
   logic ovf_q; // sticky drop flag
   logic [7:0] bus_s1_q; // bus sync stage one
   logic [7:0] bus_s2_q; // bus sync stage two
   logic ind_s1_q; // indicator sync stage one
   logic ind_s2_q; // indicator sync stage two
   logic ind_prev_q; // indicator one cycle older
   logic [7:0] a_q; // first channel word
   logic have_a_q; // first word held
   logic push_q; // pair ready to store
   logic [15:0] pair_q; // stored pair
   logic fifo_in_ready; // room in fifo
   logic fifo_out_valid; // fifo holds data
   logic [15:0] fifo_out; // fifo head
   logic [4:0] fifo_level; // words stored
   logic pop; // data register read
   logic ctrl_wr; // control register write
   logic ready; // mode normal and wake over

   assign ctrl_wr = reg_wr && (reg_addr == `DAO_REG_CTRL);
   assign pop = reg_rd && (reg_addr == `DAO_REG_DATA) && fifo_out_valid;
   assign ready = ctrl_q[1:0] == 2'b11 && wait_cnt_q == 16'h0000;

   // software registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 3'h0;
         unbuf_wait_q <= `DAO_UNBUF_WAIT_RST;
      end else if (clk_en) begin
         if (ctrl_wr) begin
            ctrl_q <= reg_wdata[2:0];
         end
         if (reg_wr && reg_addr == `DAO_REG_WAIT) begin
            unbuf_wait_q <= reg_wdata[15:0];
         end
      end
   end

   // wake wait depends on the mode being left
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wait_cnt_q <= 16'h0000;
      end else if (clk_en) begin
         if (ctrl_wr && reg_wdata[1:0] != ctrl_q[1:0]) begin
            unique case (ctrl_q[1:0])
               2'b00: begin
                  // leaving shutdown: reference must recharge
                  wait_cnt_q <= ctrl_q[`DAO_CTRL_UNBUF_BIT] ? unbuf_wait_q
                     : 16'(`DAO_WAKE_SHDN_CYC);
               end
               2'b10: begin
                  wait_cnt_q <= 16'(`DAO_WAKE_STBY_CYC);
               end
               2'b01: begin
                  // the driver wake is shorter than the pin path, so wait for the synced bus too
                  wait_cnt_q <= 16'(`DAO_WAKE_IDLE_CYC + `DAO_LINK_LAT_CYC);
               end
               2'b11: begin
                  wait_cnt_q <= 16'h0000;
               end
            endcase
         end else if (wait_cnt_q != 16'h0000) begin
            wait_cnt_q <= wait_cnt_q - 16'h0001;
         end
      end
   end

   // pins come from the device: two stages first
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_s1_q <= 8'h00;
         bus_s2_q <= 8'h00;
         ind_s1_q <= 1'b0;
         ind_s2_q <= 1'b0;
         ind_prev_q <= 1'b0;
      end else if (clk_en) begin
         bus_s1_q <= link.bus_wire;
         bus_s2_q <= bus_s1_q;
         ind_s1_q <= link.ind_wire;
         ind_s2_q <= ind_s1_q;
         ind_prev_q <= ind_s2_q;
      end
   end

   // pair words: first on indicator rise, second on its fall
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         a_q <= 8'h00;
         have_a_q <= 1'b0;
         push_q <= 1'b0;
         pair_q <= 16'h0000;
      end else if (clk_en) begin
         push_q <= 1'b0;
         if (!ready) begin
            // words before the wake ends are not trusted
            have_a_q <= 1'b0;
         end else if (ind_s2_q && !ind_prev_q) begin
            a_q <= bus_s2_q;
            have_a_q <= 1'b1;
         end else if (!ind_s2_q && ind_prev_q && have_a_q) begin
            pair_q <= {a_q, bus_s2_q};
            push_q <= 1'b1;
            have_a_q <= 1'b0;
         end
      end
   end

   // a pair offered to a full fifo is dropped and flagged
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ovf_q <= 1'b0;
      end else if (clk_en) begin
         if (push_q && !fifo_in_ready) begin
            ovf_q <= 1'b1; // set wins over clear
         end else if (reg_wr && reg_addr == `DAO_REG_STAT && reg_wdata[`DAO_STAT_OVF_BIT]) begin
            ovf_q <= 1'b0;
         end
      end
   end

   dao_fifo #(
      .WIDTH(`DAO_FIFO_WIDTH),
      .DEPTH(`DAO_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(pair_q),
      .out_valid(fifo_out_valid),
      .out_ready(pop && clk_en),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   // read data one cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            unique case (reg_addr)
               `DAO_REG_CTRL: reg_rdata <= {29'h0, ctrl_q};
               `DAO_REG_WAIT: reg_rdata <= {16'h0, unbuf_wait_q};
               `DAO_REG_STAT: reg_rdata <= {23'h0, fifo_level, 1'b0, ovf_q, fifo_out_valid, ready};
               `DAO_REG_DATA: reg_rdata <= fifo_out_valid ? {16'h0, fifo_out} : 32'h0000_0000;
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign link.power_mode_sel_lo = ctrl_q[`DAO_CTRL_LO_BIT];
   assign link.power_mode_sel_hi = ctrl_q[`DAO_CTRL_HI_BIT];
endmodule

// ===== src/dao_link_if.sv
`timescale 1ns/10ps
interface dao_link_if;
   import dao_pkg::*;
   // ----------------------------------------
   // pins
   // ----------------------------------------
   dao_code_type sample_out_bus; // driven data value
   logic bus_oe_b; // low while bus driven
   logic chan_ind; // high: first channel
   logic ind_oe_b; // low while indicator driven
   logic sample_clk; // sampling clock
   logic power_mode_sel_lo; // first mode pin
   logic power_mode_sel_hi; // second mode pin
   // levels seen by the host; a released pin shows the inverse so an early sample shows up
   wire [7:0] bus_wire;
   wire ind_wire;
   assign bus_wire = bus_oe_b ? ~sample_out_bus : sample_out_bus;
   assign ind_wire = ind_oe_b ? ~chan_ind : chan_ind;

   modport dev (
      output sample_out_bus,
      output bus_oe_b,
      output chan_ind,
      output ind_oe_b,
      output sample_clk,
      input power_mode_sel_lo,
      input power_mode_sel_hi
   );
   modport host (
      input bus_wire,
      input ind_wire,
      input sample_clk,
      output power_mode_sel_lo,
      output power_mode_sel_hi
   );
endinterface

// ===== src/dao_pkg.sv
package dao_pkg;
   // power mode seen from the two mode pins
   typedef enum logic [1:0] {mode_shutdown, mode_standby, mode_idle, mode_normal} dao_mode_type;
   // one offset binary sample
   typedef logic [7:0] dao_code_type;
endpackage

// ===== src/dao_regs.svh
// Functional notes
// - samples coded offset binary, zero gives 128
// - input at +127 LSB or above gives 255
// - input at -128 LSB or below gives 0
// - mode chosen only by two mode pins
// - both pins low: all off, outputs released
// - low/high: reference and clock on, converters off
// - high/low: all running, outputs released
// - both high: everything on, outputs driven
// - host waits 20 us after shutdown
// - unbuffered reference: host wait is programmable
// - host waits 5.4 us after standby
// - host waits 5 ns after idle
// - outputs re-enable showing last converted word
// - both channels sampled on same rising edge
// - first channel on rise, second on fall
// - indicator high for first, low for second
// - latency 5 and 5.5 sample clocks
`ifndef DAO_REGS_SVH
`define DAO_REGS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define DAO_CLK_MHZ 40
`define DAO_WAKE_SHDN_US 20
`define DAO_WAKE_STBY_NS 5400
`define DAO_WAKE_IDLE_NS 5
`define DAO_WAKE_SHDN_CYC (`DAO_WAKE_SHDN_US * `DAO_CLK_MHZ)
`define DAO_WAKE_STBY_CYC ((`DAO_WAKE_STBY_NS * `DAO_CLK_MHZ + 999) / 1000)
`define DAO_WAKE_IDLE_CYC ((`DAO_WAKE_IDLE_NS * `DAO_CLK_MHZ + 999) / 1000)
// pin path: two device syncs, mode, enable, then two host syncs
`define DAO_LINK_LAT_CYC 6
`define DAO_UNBUF_WAIT_RST 16'h0320
`define DAO_LAT_A 5

// ----------------------------------------
// codes
// ----------------------------------------
`define DAO_CODE_MID 8'h80
`define DAO_CODE_MAX 8'hff
`define DAO_CODE_MIN 8'h00
`define DAO_LSB_HI 9'sd127
`define DAO_LSB_LO -9'sd128

// ----------------------------------------
// host register map
// ----------------------------------------
`define DAO_REG_CTRL 4'h0
`define DAO_REG_WAIT 4'h4
`define DAO_REG_STAT 4'h8
`define DAO_REG_DATA 4'hc
`define DAO_CTRL_LO_BIT 0
`define DAO_CTRL_HI_BIT 1
`define DAO_CTRL_UNBUF_BIT 2
`define DAO_STAT_READY_BIT 0
`define DAO_STAT_AVAIL_BIT 1
`define DAO_STAT_OVF_BIT 2
`define DAO_STAT_LVL_LSB 4
`define DAO_FIFO_DEPTH 16
`define DAO_FIFO_WIDTH 16

`endif

// ===== testbench/dao_link_monitor.sv
`timescale 1ns/10ps
// ----------------------------------------
// link checker
// ----------------------------------------
module dao_link_monitor (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire dao_pkg::dao_code_type sample_out_bus,
   input wire logic bus_oe_b,
   input wire logic chan_ind,
   input wire logic ind_oe_b,
   input wire logic sample_clk,
   input wire logic power_mode_sel_lo,
   input wire logic power_mode_sel_hi
);
   import dao_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic both_hi; // pins ask for normal mode
   logic both_lo; // pins ask for shutdown
   assign both_hi = power_mode_sel_lo && power_mode_sel_hi;
   assign both_lo = !power_mode_sel_lo && !power_mode_sel_hi;
   // pins pass two sync flops, mode flop, then the enables: four edges
   property p_drive_src; !bus_oe_b |-> $past(both_hi, 4); endproperty
   a_drive_src: assert property (p_drive_src) else $error("bus driven outside normal mode");
   property p_release; !both_hi |-> ##4 bus_oe_b; endproperty
   a_release: assert property (p_release) else $error("bus not released");
   property p_drive; both_hi [*5] |-> !bus_oe_b; endproperty
   a_drive: assert property (p_drive) else $error("bus not driven in normal mode");
   property p_oe_pair; ind_oe_b == bus_oe_b; endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("indicator and bus enables differ");
   property p_clk_stop; both_lo [*8] |-> !sample_clk; endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("sample clock runs in shutdown");
   property p_clk_run; !both_lo [*8] |-> sample_clk != $past(sample_clk); endproperty
   a_clk_run: assert property (p_clk_run) else $error("sample clock stalled");
   // first event after enabling may repeat the frozen indicator, so skip two cycles
   property p_ind_alt; (!bus_oe_b) [*3] |-> chan_ind != $past(chan_ind); endproperty
   a_ind_alt: assert property (p_ind_alt) else $error("indicator not alternating");
   property p_latch_hold; (!power_mode_sel_lo) [*8] |-> $stable(sample_out_bus); endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch moved with converters off");
   property p_first_word; $fell(bus_oe_b) && !$past(power_mode_sel_lo, 5) |-> $stable(sample_out_bus); endproperty
   a_first_word: assert property (p_first_word) else $error("enabled word is not the held one");
   c_enable: cover property ($fell(bus_oe_b));
   c_ind: cover property (!bus_oe_b && $rose(chan_ind));
   c_stop: cover property (both_lo [*8]);
endmodule

// ===== testbench/tb_dual_adc_output_power_ctrl.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_dual_adc_output_power_ctrl;
   import dao_pkg::*;
   typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} dao_note_type;
   logic clk_sys, rst_b, clk_en, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic signed [8:0] in_a_lsb, in_b_lsb;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, last_rd;
   dao_mode_type mode_q;
   logic adc_on_q, ref_on_q, clk_dist_on_q;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'hef3f;
   dao_note_type notes[$]; // expected read results, oldest first
   dao_note_type nt;
   localparam logic signed [8:0] VALS [10] = '{1, 127, -128, 0, 200, -1, -256, 126, 255, -127};
   dao_link_if u_dao_link_if ();
   dao_adc_end u_dao_adc_end (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .in_a_lsb(in_a_lsb),
      .in_b_lsb(in_b_lsb), .mode_q(mode_q), .adc_on_q(adc_on_q), .ref_on_q(ref_on_q),
      .clk_dist_on_q(clk_dist_on_q), .link(u_dao_link_if));
   dao_ctrl_end u_dao_ctrl_end (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(u_dao_link_if));
   dao_link_monitor u_dao_link_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
      .sample_out_bus(u_dao_link_if.sample_out_bus), .bus_oe_b(u_dao_link_if.bus_oe_b),
      .chan_ind(u_dao_link_if.chan_ind), .ind_oe_b(u_dao_link_if.ind_oe_b),
      .sample_clk(u_dao_link_if.sample_clk), .power_mode_sel_lo(u_dao_link_if.power_mode_sel_lo),
      .power_mode_sel_hi(u_dao_link_if.power_mode_sel_hi));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // own model of the output coding, clipped at both ends
   function automatic logic [7:0] code(input logic signed [8:0] v);
      if (v >= 127) return 8'hff;
      if (v <= -128) return 8'h00;
      return v[7:0] ^ 8'h80;
   endfunction
   task automatic close_out();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // strobes drop one edge before the next request, so no double assignment
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // a zero mask only fetches the word into last_rd
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
      notes.push_back('{nm, e, m});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask
   // bounded poll of the ready flag
   task automatic wait_ready();
      for (int i = 0; i < 1000; i++) begin
         rd(4'h8, 0, 0, "");
         if (last_rd[0] === 1'b1) return;
      end
      num_errors++;
   endtask
   // read data stand in the cycle after the strobe; look mid-cycle
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
   end
   always @(negedge clk_sys) begin
      if (rd_d) begin
         last_rd = reg_rdata;
         nt = notes.pop_front();
         if (nt.msk != 0) `CHK(nt.nm, nt.exp & nt.msk, reg_rdata & nt.msk)
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      close_out();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int n;
      logic [7:0] ca, cb;
      rst_b = 1'b0;
      clk_en = 1'b1;
      in_a_lsb = '0;
      in_b_lsb = '0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(4'h0, 0, 32'hffffffff, "ctrl_rst");
      rd(4'h4, 32'h320, 32'hffff, "wait_rst");
      rd(4'h8, 0, 32'h1f7, "stat_rst");
      rd(4'h2, 0, 32'hffffffff, "unmapped");
      // every pin combination; lo pin is bit 0, hi pin bit 1
      for (int m = 0; m < 4; m++) begin
         wr(4'h0, m);
         repeat (6) @(posedge clk_sys);
         rd(4'h0, m, 32'h3, "ctrl");
         #1;
         `CHK("mode", (m == 1) ? mode_idle : (m == 2) ? mode_standby : dao_mode_type'(m), mode_q)
         `CHK("adc_on", m[0], adc_on_q)
         `CHK("ref_on", m != 0, ref_on_q)
         `CHK("clk_on", m != 0, clk_dist_on_q)
         `CHK("oe_b", m != 3, u_dao_link_if.bus_oe_b)
         @(posedge clk_sys);
      end
      // standby wake: still busy a few cycles early, ready just after
      repeat (200) @(posedge clk_sys);
      rd(4'h8, 0, 32'h1, "stby_busy");
      repeat (6) @(posedge clk_sys);
      rd(4'h8, 32'h1, 32'h1, "stby_done");
      // coding table and latency; neighbouring values give different codes
      foreach (VALS[i]) begin
         @(posedge clk_sys);
         in_a_lsb <= VALS[i];
         in_b_lsb <= VALS[9 - i];
         n = 0;
         do begin
            @(posedge clk_sys);
            #1;
            n++;
         end while (n < 20 && !(u_dao_link_if.ind_wire === 1'b1 && u_dao_link_if.bus_wire === code(VALS[i])));
         `CHK("lat_a", 1'b1, n == 11 || n == 12)
         `CHK("code_a", code(VALS[i]), u_dao_link_if.bus_wire)
         @(posedge clk_sys);
         #1;
         `CHK("code_b", code(VALS[9 - i]), u_dao_link_if.bus_wire)
         `CHK("ind_b", 1'b0, u_dao_link_if.ind_wire)
      end
      // standby freezes the latch; wake shows the held word
      @(posedge clk_sys);
      in_a_lsb <= 9'sd5;
      in_b_lsb <= 9'sd5;
      repeat (30) @(posedge clk_sys);
      wr(4'h0, 32'h2);
      in_a_lsb <= -9'sd5;
      in_b_lsb <= -9'sd5;
      repeat (20) @(posedge clk_sys);
      wr(4'h0, 32'h3);
      for (int k = 0; k < 10 && u_dao_link_if.bus_oe_b !== 1'b0; k++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK("wake_word", code(9'sd5), u_dao_link_if.bus_wire)
      @(posedge clk_sys);
      wait_ready();
      // fifo: empty it in idle, overfill in normal, drain again
      wr(4'h0, 32'h1);
      repeat (17) rd(4'hc, 0, 0, "");
      wr(4'h8, 32'h4);
      rd(4'h8, 0, 32'h1f6, "empty");
      in_a_lsb <= 9'($random(seed));
      in_b_lsb <= 9'($random(seed));
      repeat (30) @(posedge clk_sys);
      ca = code(in_a_lsb);
      cb = code(in_b_lsb);
      wr(4'h0, 32'h3);
      rd(4'h8, 0, 32'h1, "idle_busy");
      repeat (60) @(posedge clk_sys);
      rd(4'h8, 32'h107, 32'h1f7, "full");
      wr(4'h0, 32'h1);
      repeat (16) rd(4'hc, {ca, cb}, 32'hffff, "pair");
      rd(4'h8, 32'h4, 32'h1f6, "drained");
      rd(4'hc, 0, 32'hffffffff, "empty_data");
      wr(4'h8, 32'h4);
      rd(4'h8, 0, 32'h4, "ovf_clr");
      // reference wake: programmed wait first, then the fixed shutdown wait
      wr(4'h4, 32'h20);
      wr(4'h0, 32'h4);
      wr(4'h0, 32'h7);
      rd(4'h8, 0, 32'h1, "unbuf_busy");
      repeat (32) @(posedge clk_sys);
      rd(4'h8, 32'h1, 32'h1, "unbuf_done");
      wr(4'h0, 32'h0);
      wr(4'h0, 32'h3);
      repeat (780) @(posedge clk_sys);
      rd(4'h8, 0, 32'h1, "shdn_busy");
      repeat (20) @(posedge clk_sys);
      rd(4'h8, 32'h1, 32'h1, "shdn_done");
      repeat (4) @(posedge clk_sys);
      close_out();
   end
endmodule
